// file: rtl/dte_serial_pkg.sv
// Package for the terminal-side handshake and synchronous bit clock block.
// Assumes a single 250 MHz system clock; the handshake pins are level signals, logic 0 active.
package dte_serial_pkg;
	localparam int unsigned SYS_CLK_HZ      = 250000000;
	localparam int unsigned BIT_RATE_HZ     = 2400;
	localparam int unsigned HALF_BIT_CYCLES = SYS_CLK_HZ / (2 * BIT_RATE_HZ);
	localparam int unsigned CTS_DELAY_US    = 10;
	localparam int unsigned CTS_DELAY_CYCLES = (CTS_DELAY_US * (SYS_CLK_HZ / 1000000));
	localparam int unsigned MARK_HOLD_US    = 1000;
	localparam int unsigned MARK_HOLD_CYCLES = (MARK_HOLD_US * (SYS_CLK_HZ / 1000000));
	localparam logic        LINE_ACTIVE     = 1'b0;
	localparam logic        LINE_IDLE       = 1'b1;
	typedef enum logic [1:0] {
		ST_RECEIVE,
		ST_TURN_ON,
		ST_TRANSMIT,
		ST_DRAIN
	} mode_type;
endpackage

// file: rtl/bit_clock_gen.sv
// Bit clock generator: a divider that gives a 50 percent clock and a strobe at its rising edge.
// Assumes run is synchronous to sys_clk; the clock parks high while stopped.
`timescale 1ns/1ns
module bit_clock_gen #(
	parameter int unsigned HALF_CYCLES = dte_serial_pkg::HALF_BIT_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic run,
	output logic      bit_clk,
	output logic      rise_pulse
);
	initial begin
		if (HALF_CYCLES < 2)
			$error("bit_clock_gen: HALF_CYCLES must be at least 2");
	end
	logic [31:0] count_q;
	logic        clk_q;
	wire         wrap = (count_q == HALF_CYCLES - 1);
	// Truncated integer division of the system clock keeps the rate far inside the tolerance
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 32'h0;
			clk_q   <= 1'b1;
		end else if (!run) begin
			count_q <= 32'h0;
			clk_q   <= 1'b1;
		end else begin
			count_q <= wrap ? 32'h0 : count_q + 32'h1;
			clk_q   <= wrap ? ~clk_q : clk_q;
		end
	end
	assign bit_clk    = clk_q;
	assign rise_pulse = run && wrap && !clk_q;
endmodule // bit_clock_gen

// file: rtl/dte_serial_handshake_clocks.sv
// Terminal-side handshake and synchronous bit clocks of the modem's serial port.
// Assumes terminal pins are asynchronous; link-side transmit data moves one bit per rising transmit bit clock.
`timescale 1ns/1ns
module dte_serial_handshake_clocks #(
	parameter int unsigned HALF_CYCLES = dte_serial_pkg::HALF_BIT_CYCLES,
	parameter int unsigned CTS_CYCLES  = dte_serial_pkg::CTS_DELAY_CYCLES,
	parameter int unsigned HOLD_CYCLES = dte_serial_pkg::MARK_HOLD_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic rts_b,
	input  wire logic dtr_b,
	input  wire logic txd,
	input  wire logic half_duplex,
	input  wire logic sync_clocks_en,
	input  wire logic link_rx_bit,
	input  wire logic link_rx_valid,
	output logic      cts_b,
	output logic      rxd,
	output logic      tx_bit_clock,
	output logic      rx_bit_clock,
	output logic      tx_mode,
	output logic      link_tx_bit,
	output logic      link_tx_valid
);
	initial begin
		if (CTS_CYCLES < 1 || HOLD_CYCLES < 1)
			$error("dte_serial_handshake_clocks: delays must be at least one cycle");
	end
	// Two-flop synchronisers for every terminal pin
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 4'hf;
			sync2_q <= 4'hf;
		end else begin
			sync1_q <= {txd, dtr_b, rts_b, half_duplex};
			sync2_q <= sync1_q;
		end
	end
	wire rts_s  = sync2_q[1];
	wire dtr_s  = sync2_q[2];
	wire txd_s  = sync2_q[3];
	wire hdx_s  = sync2_q[0];
	logic rts_prev_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			rts_prev_q <= dte_serial_pkg::LINE_IDLE;
		else
			rts_prev_q <= rts_s;
	end
	wire rts_fall = rts_prev_q && !rts_s;
	wire rts_rise = !rts_prev_q && rts_s;
	dte_serial_pkg::mode_type mode_q;
	dte_serial_pkg::mode_type mode_d;
	logic [31:0] timer_q;
	logic [31:0] timer_d;
	logic        hold_q;
	logic        hold_d;
	logic        tx_rise;
	logic        rx_rise;
	wire timer_done = (timer_q == 32'h0);
	always_comb begin
		mode_d  = mode_q;
		timer_d = timer_done ? 32'h0 : timer_q - 32'h1;
		hold_d  = hold_q && !timer_done;
		case (mode_q)
			dte_serial_pkg::ST_RECEIVE: begin
				if (!hdx_s && rts_s == dte_serial_pkg::LINE_ACTIVE) begin
					mode_d = dte_serial_pkg::ST_TRANSMIT;
				end else if (hdx_s && (rts_fall || rts_s == dte_serial_pkg::LINE_ACTIVE)) begin
					mode_d  = dte_serial_pkg::ST_TURN_ON;
					timer_d = CTS_CYCLES - 1;
				end
			end
			dte_serial_pkg::ST_TURN_ON: begin
				if (rts_s != dte_serial_pkg::LINE_ACTIVE)
					mode_d = dte_serial_pkg::ST_RECEIVE;
				else if (timer_done)
					mode_d = dte_serial_pkg::ST_TRANSMIT;
			end
			dte_serial_pkg::ST_TRANSMIT: begin
				if (rts_rise || rts_s != dte_serial_pkg::LINE_ACTIVE) begin
					mode_d  = dte_serial_pkg::ST_DRAIN;
					hold_d  = 1'b1;
					timer_d = HOLD_CYCLES - 1;
				end
			end
			dte_serial_pkg::ST_DRAIN: begin
				// The bit under way is forwarded at the rising clock that ends transmit mode
				if (tx_rise || !sync_clocks_en)
					mode_d = dte_serial_pkg::ST_RECEIVE;
			end
			default: mode_d = dte_serial_pkg::ST_RECEIVE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q  <= dte_serial_pkg::ST_RECEIVE;
			timer_q <= 32'h0;
			hold_q  <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			timer_q <= timer_d;
			hold_q  <= hold_d;
		end
	end
	wire in_tx = (mode_q == dte_serial_pkg::ST_TRANSMIT) || (mode_q == dte_serial_pkg::ST_DRAIN);
	wire cts_on = (mode_q == dte_serial_pkg::ST_TRANSMIT);
	// Clocks stop when disabled so unconnected outputs never toggle
	wire tx_run = sync_clocks_en && in_tx;
	wire rx_run = sync_clocks_en;
	bit_clock_gen #(.HALF_CYCLES(HALF_CYCLES)) u_tx_clk (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.run        (tx_run),
		.bit_clk    (tx_bit_clock),
		.rise_pulse (tx_rise)
	);
	bit_clock_gen #(.HALF_CYCLES(HALF_CYCLES)) u_rx_clk (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.run        (rx_run),
		.bit_clk    (rx_bit_clock),
		.rise_pulse (rx_rise)
	);
	logic cts_q;
	logic rxd_q;
	logic rx_cap_q;
	logic tx_bit_q;
	logic tx_valid_q;
	logic rx_clk_q;
	// Receive data changes just after the falling clock so each rise sits mid-bit
	wire rx_fall = rx_run && rx_clk_q && !rx_bit_clock;
	wire rx_mark = hold_q || !link_rx_valid;
	// The bit already under way when request-to-send rises is still forwarded
	wire drain_s = (mode_q == dte_serial_pkg::ST_DRAIN);
	wire tx_take = tx_rise && (!cts_q || drain_s) && !dtr_s;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cts_q      <= dte_serial_pkg::LINE_IDLE;
			rxd_q      <= dte_serial_pkg::LINE_IDLE;
			rx_cap_q   <= dte_serial_pkg::LINE_IDLE;
			tx_bit_q   <= dte_serial_pkg::LINE_IDLE;
			tx_valid_q <= 1'b0;
			rx_clk_q   <= dte_serial_pkg::LINE_IDLE;
		end else begin
			rx_clk_q   <= rx_bit_clock;
			cts_q      <= cts_on ? dte_serial_pkg::LINE_ACTIVE : dte_serial_pkg::LINE_IDLE;
			rx_cap_q   <= rx_mark ? dte_serial_pkg::LINE_IDLE : link_rx_bit;
			// Mark has priority so a bit captured before the hold cannot slip out
			rxd_q      <= rx_mark ? dte_serial_pkg::LINE_IDLE : (rx_fall ? rx_cap_q : rxd_q);
			tx_bit_q   <= tx_take ? txd_s : tx_bit_q;
			tx_valid_q <= tx_take;
		end
	end
	assign cts_b         = cts_q;
	assign rxd           = rxd_q;
	assign tx_mode       = in_tx;
	assign link_tx_bit   = tx_bit_q;
	assign link_tx_valid = tx_valid_q;
endmodule // dte_serial_handshake_clocks

// file: tb/dte_serial_asserts.sv
// Checker: handshake timing and bit clock shape at the block's ports.
// Bound into the top module; sees its ports only.
`timescale 1ns/1ns
module dte_serial_asserts #(
	parameter int unsigned HALF_CYCLES = 4,
	parameter int unsigned CTS_CYCLES  = 5
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic rts_b,
	input wire logic dtr_b,
	input wire logic half_duplex,
	input wire logic sync_clocks_en,
	input wire logic cts_b,
	input wire logic rxd,
	input wire logic tx_bit_clock,
	input wire logic rx_bit_clock,
	input wire logic tx_mode,
	input wire logic link_tx_valid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	chk_rx_park: assert property (!sync_clocks_en[*5] |-> rx_bit_clock) else $error("rx clock runs");
	chk_tx_park: assert property (!tx_mode[*3] |-> tx_bit_clock) else $error("tx clock runs");
	chk_rx_period: assert property (sync_clocks_en[*8] ##0 $rose(rx_bit_clock) |->
		!$past(rx_bit_clock, HALF_CYCLES) && $past(rx_bit_clock, HALF_CYCLES + 1)) else $error("rx period");
	chk_tx_period: assert property ((tx_mode && sync_clocks_en)[*8] ##0 $rose(tx_bit_clock) |->
		!$past(tx_bit_clock, HALF_CYCLES) && $past(tx_bit_clock, HALF_CYCLES + 1)) else $error("tx period");
	chk_cts_mode: assert property (!cts_b |-> tx_mode) else $error("clear without transmit");
	chk_hdx_delay: assert property (half_duplex && $fell(cts_b) |-> !$past(rts_b, CTS_CYCLES + 2))
		else $error("clear too early");
	chk_rts_drop: assert property (rts_b[*6] |-> cts_b) else $error("clear held");
	chk_dtr_refuse: assert property (dtr_b[*6] |-> !link_tx_valid) else $error("bit taken");
	chk_rxd_hold: assert property (tx_mode && $rose(rts_b) ##1 rts_b[*4] |=> rxd[*8])
		else $error("rxd not held");
endmodule // dte_serial_asserts
bind dte_serial_handshake_clocks dte_serial_asserts #(.HALF_CYCLES(HALF_CYCLES), .CTS_CYCLES(CTS_CYCLES)) chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .rts_b(rts_b), .dtr_b(dtr_b), .half_duplex(half_duplex), .rxd(rxd),
	.sync_clocks_en(sync_clocks_en), .cts_b(cts_b), .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
	.tx_mode(tx_mode), .link_tx_valid(link_tx_valid));

// file: tb/terminal_model.sv
// Terminal model: request-to-send and transmit data.
// Bits change on the falling bit clock, so the rise lands mid-bit.
`timescale 1ns/1ns
module terminal_model (
	input  wire logic       sys_clk,
	input  wire logic       send,
	input  wire logic       dtr_b,
	input  wire logic       cts_b,
	input  wire logic       tx_bit_clock,
	input  wire logic [7:0] tx_byte,
	output logic            rts_b,
	output logic            txd
);
	logic       clk_q = 1'b1;
	logic [2:0] idx_q = 3'h0;
	initial rts_b = 1'b1;
	initial txd = 1'b1;
	always @(negedge sys_clk) begin
		rts_b <= !send;
		clk_q <= tx_bit_clock;
		if (rts_b | cts_b | dtr_b)
			txd <= 1'b1;
		else if (clk_q && !tx_bit_clock) begin
			txd   <= tx_byte[idx_q];
			idx_q <= idx_q + 3'h1;
		end
	end
endmodule // terminal_model

// file: tb/test_dte_serial_handshake_clocks.sv
// Bench: terminal model at the far side; bench drives options and link receive data.
// Small counts give 8 cycles a bit on the 4 ns clock.
`timescale 1ns/1ns
module test_dte_serial_handshake_clocks;
	logic sys_clk, rst_b, send, dtr_b, half_duplex, sync_clocks_en, link_rx_bit, link_rx_valid, rts_b, txd;
	logic cts_b, rxd, tx_bit_clock, rx_bit_clock, tx_mode, link_tx_bit, link_tx_valid;
	int   mismatches, checks, n;
	dte_serial_handshake_clocks #(.HALF_CYCLES(4), .CTS_CYCLES(5), .HOLD_CYCLES(20)) dut (.sys_clk(sys_clk),
		.rst_b(rst_b), .rts_b(rts_b), .dtr_b(dtr_b), .txd(txd), .half_duplex(half_duplex), .rxd(rxd),
		.sync_clocks_en(sync_clocks_en), .link_rx_bit(link_rx_bit), .link_rx_valid(link_rx_valid), .cts_b(cts_b),
		.tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .tx_mode(tx_mode), .link_tx_bit(link_tx_bit),
		.link_tx_valid(link_tx_valid));
	terminal_model term (.sys_clk(sys_clk), .send(send), .dtr_b(dtr_b), .cts_b(cts_b),
		.tx_bit_clock(tx_bit_clock), .tx_byte(8'h5a), .rts_b(rts_b), .txd(txd));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		if (got !== exp)
			mismatches++;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic t_fdx;
		half_duplex = 1'b0;
		send = 1'b1;
		for (n = 0; n < 50 && cts_b !== 1'b0; n++) cyc(1);
		check(tx_mode, 1'b1);
		n = 0;
		repeat (48) begin
			cyc(1);
			if (link_tx_valid === 1'b1)
				check(link_tx_bit, txd);
			if (link_tx_valid === 1'b1)
				n++;
		end
		check(n >= 5, 1'b1);
		send = 1'b0;
		cyc(4);
		{link_rx_valid, link_rx_bit} = 2'h2;
		repeat (20) begin
			cyc(1);
			check(rxd, 1'b1);
		end
		cyc(40);
		check({cts_b, tx_mode, rxd}, 3'h4);
		link_rx_valid = 1'b0;
		$display("full duplex done");
	endtask
	task automatic t_hdx;
		half_duplex = 1'b1;
		cyc(4);
		send = 1'b1;
		for (n = 0; n < 50 && cts_b !== 1'b0; n++) cyc(1);
		check(n >= 7 && n <= 12, 1'b1);
		send = 1'b0;
		cyc(30);
		check(tx_mode, 1'b0);
		$display("half duplex done");
	endtask
	task automatic t_dtr_park;
		{half_duplex, dtr_b, send} = 3'h3;
		n = 0;
		repeat (48) begin
			cyc(1);
			if (link_tx_valid !== 1'b0)
				n++;
		end
		check(n, 8'h0);
		sync_clocks_en = 1'b0;
		cyc(6);
		repeat (24) begin
			cyc(1);
			check({rx_bit_clock, tx_bit_clock}, 8'h3);
		end
		{sync_clocks_en, dtr_b, send} = 3'h4;
		cyc(30);
		$display("refuse and park done");
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		#20000;
		mismatches++;
		stop_test;
	end
	initial begin
		{rst_b, send, dtr_b, half_duplex, sync_clocks_en, link_rx_bit, link_rx_valid} = 7'h06;
		cyc(2);
		rst_b = 1'b1;
		cyc(4);
		t_fdx;
		t_hdx;
		t_dtr_park;
		stop_test;
	end
endmodule // test_dte_serial_handshake_clocks
